// ===== hdl/flash_command_controller.sv
// Flash command controller: AXI4-Lite register file, command sequencer
// toward a flash array, protection and signature logic.
// Assumes the array returns read data one cycle after an arr_rd pulse,
// and that por_nrst falls only at power-up (it keeps saved protection).
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Interrupt on completion only when enabled
// - Erase/write run only with enable bit
// - Read loads data register; null idles
// - Single write programs word, about 50 us
// - Erase page then program, about 24 ms
// - Verify compares word; mismatch sets fail
// - Page erase clears only addressed page
// - Mass erase user area, 2.48 s
// - Mass erase needs enabling sequence first
// - Signature over flash, 32778 cycles
// - Protect saves value once; key to change
// - Ping does nothing but completes with interrupt
// - Command reads 0x07 after codes 0-6
// - Saved protection acts after reset, keyed
// - Volatile protection immediate, reset restores
// - Protection bit 31 clear blocks reads
// - Bits 30-0 clear block group writes
// - Each of bits 30-0 covers 2 kB, writes and erases only
// - Status busy, pass, fail, irq; read clears pass, fail and irq, not busy
module flash_command_controller #(
  parameter logic [31:0] WRITE_CYC = 32'(flash_ctrl_pkg::WRITE_CYCLES),
  parameter logic [31:0] ERASE_CYC = 32'(flash_ctrl_pkg::PAGE_ERASE_CYCLES),
  parameter logic [31:0] MASS_CYC  = 32'(flash_ctrl_pkg::MASS_CYCLES),
  parameter logic [31:0] SIGN_CYC  = 32'(flash_ctrl_pkg::SIGN_CYCLES),
  parameter logic [15:0] SIGN_WORDS = 16'(flash_ctrl_pkg::SIGN_WORDS)
) (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        por_nrst,
  // AXI4-Lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Flash array
  output logic             arr_rd,
  output logic             arr_wr,
  output logic             arr_erase_page,
  output logic             arr_erase_all,
  output logic [14:0]      arr_addr,
  output logic [15:0]      arr_wdata,
  input  wire logic [15:0] arr_rdata,
  // Interrupt
  output logic             flash_irq
);

  typedef enum logic [2:0] {
    S_IDLE, S_DISPATCH, S_RD_WAIT, S_RD_TAKE, S_ERASE_WAIT, S_WAIT,
    S_SIGN, S_FINISH
  } state_e;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [23:0] sig_step(input logic [23:0] acc,
                                           input logic [15:0] d);
    return {acc[22:0], acc[23]} ^ {8'h00, d};
  endfunction

  // Register file
  logic [15:0] mode_q;
  logic [7:0]  cmd_q;
  logic [15:0] data_q;
  logic [15:0] addr_q;
  logic [23:0] sign_q;
  logic [31:0] prot_q;
  logic [31:0] hide_q;
  // Power-on persistent protection state
  logic [31:0] saved_q;
  logic [31:0] key_q;
  logic        key_set_q;
  // Protection in force since last reset
  logic [31:0] active_q;
  logic        load_q;
  // Status
  logic        pass_q;
  logic        fail_q;
  logic        irqf_q;
  // Sequencer
  state_e      st_q;
  logic [31:0] tmr_q;
  logic [15:0] sidx_q;
  logic        sfold_q;
  logic        res_fail_q;
  // Bus slave
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;

  // Bus decode
  wire         wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire         ar_fire  = s_axi_arvalid && s_axi_arready;
  wire         wsel_mode = awaddr_q == flash_ctrl_pkg::OFF_MODE;
  wire         wsel_cmd  = awaddr_q == flash_ctrl_pkg::OFF_CMD;
  wire         wsel_data = awaddr_q == flash_ctrl_pkg::OFF_DATA;
  wire         wsel_addr = awaddr_q == flash_ctrl_pkg::OFF_ADDR;
  wire         wsel_prot = awaddr_q == flash_ctrl_pkg::OFF_PROT;
  wire         wsel_hide = awaddr_q == flash_ctrl_pkg::OFF_HIDE;
  wire         wsel_ro   = awaddr_q == flash_ctrl_pkg::OFF_STATUS ||
                           awaddr_q == flash_ctrl_pkg::OFF_SIGN;
  wire         wmapped   = wsel_mode || wsel_cmd || wsel_data ||
                           wsel_addr || wsel_prot || wsel_hide || wsel_ro;
  wire  [31:0] wmerged_mode = merge({16'h0000, mode_q}, wdata_q, wstrb_q);
  wire  [31:0] wmerged_data = merge({16'h0000, data_q}, wdata_q, wstrb_q);
  wire  [31:0] wmerged_addr = merge({16'h0000, addr_q}, wdata_q, wstrb_q);
  wire  [31:0] wmerged_prot = merge(prot_q, wdata_q, wstrb_q);
  wire  [31:0] wmerged_hide = merge(hide_q, wdata_q, wstrb_q);

  wire         busy     = st_q != S_IDLE;
  wire         rsel_stat = s_axi_araddr == flash_ctrl_pkg::OFF_STATUS;
  wire  [7:0]  stat_val = {2'b00, 1'b1, 1'b0, irqf_q, busy, fail_q, pass_q};
  wire  [31:0] rd_mux =
    rsel_stat ? {24'h000000, stat_val} :
    s_axi_araddr == flash_ctrl_pkg::OFF_MODE ? {16'h0000, mode_q} :
    s_axi_araddr == flash_ctrl_pkg::OFF_CMD  ? {24'h000000, cmd_q} :
    s_axi_araddr == flash_ctrl_pkg::OFF_DATA ? {16'h0000, data_q} :
    s_axi_araddr == flash_ctrl_pkg::OFF_ADDR ? {16'h0000, addr_q} :
    s_axi_araddr == flash_ctrl_pkg::OFF_SIGN ? {8'h00, sign_q} :
    s_axi_araddr == flash_ctrl_pkg::OFF_PROT ? prot_q :
    s_axi_araddr == flash_ctrl_pkg::OFF_HIDE ? hide_q : 32'h00000000;
  wire         rmapped = rsel_stat ||
    s_axi_araddr == flash_ctrl_pkg::OFF_MODE ||
    s_axi_araddr == flash_ctrl_pkg::OFF_CMD  ||
    s_axi_araddr == flash_ctrl_pkg::OFF_DATA ||
    s_axi_araddr == flash_ctrl_pkg::OFF_ADDR ||
    s_axi_araddr == flash_ctrl_pkg::OFF_SIGN ||
    s_axi_araddr == flash_ctrl_pkg::OFF_PROT ||
    s_axi_araddr == flash_ctrl_pkg::OFF_HIDE;

  // A command starts only from idle; a write while busy is dropped
  wire         start = wr_fire && wsel_cmd && wstrb_q[0] && !busy;

  // Protection checks
  wire  [31:0] eff_prot = active_q & hide_q;
  wire  [4:0]  group    = addr_q[15:11];
  wire         rd_ok    = eff_prot[flash_ctrl_pkg::PROT_READ_BIT];
  wire         grp_ok   = group != flash_ctrl_pkg::KERNEL_GROUP &&
                          eff_prot[group];
  wire         cmd_en   = mode_q[flash_ctrl_pkg::MODE_CMD_EN_BIT];
  wire         wr_ok    = cmd_en && grp_ok && !load_q;
  wire         mass_ok  = cmd_en && !load_q &&
                          &eff_prot[30:0] &&
                          data_q == flash_ctrl_pkg::MASS_DATA_KEY &&
                          addr_q == flash_ctrl_pkg::MASS_ADDR_KEY;
  wire  [31:0] key_in   = {addr_q, data_q};
  wire         key_en   = mode_q[flash_ctrl_pkg::MODE_KEY_EN_BIT] &&
                          !mode_q[flash_ctrl_pkg::MODE_KEY_OFF_BIT];
  wire         prot_ok  = key_en && (!key_set_q ||
                          (key_in == key_q &&
                           key_q != flash_ctrl_pkg::PERM_KEY));
  wire         dispatch = st_q == S_DISPATCH;
  wire         prot_commit = dispatch &&
                          cmd_q == flash_ctrl_pkg::CMD_PROTECT && prot_ok;
  wire         mass_done = st_q == S_WAIT && tmr_q == 32'h00000001 &&
                          arr_addr == 15'h7FFF;
  wire         rd_load  = st_q == S_RD_TAKE &&
                          cmd_q == flash_ctrl_pkg::CMD_READ;
  wire         code_low = cmd_q <= flash_ctrl_pkg::CMD_MASS;
  wire         finish   = st_q == S_FINISH;
  wire         rd_status = ar_fire && rsel_stat;

  // AXI4-Lite write channels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awaddr_q      <= 32'h00000000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= flash_ctrl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmapped ? flash_ctrl_pkg::RESP_OKAY
                                : flash_ctrl_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= flash_ctrl_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rmapped ? flash_ctrl_pkg::RESP_OKAY
                               : flash_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software registers; data also loaded by a read command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= flash_ctrl_pkg::MODE_RESET;
      data_q <= flash_ctrl_pkg::DATA_RESET;
      addr_q <= flash_ctrl_pkg::ADDR_RESET;
      prot_q <= flash_ctrl_pkg::PROT_RESET;
      hide_q <= flash_ctrl_pkg::HIDE_RESET;
    end else begin
      if (wr_fire && wsel_mode) mode_q <= wmerged_mode[15:0];
      if (wr_fire && wsel_addr) addr_q <= wmerged_addr[15:0];
      if (wr_fire && wsel_prot) prot_q <= wmerged_prot;
      if (wr_fire && wsel_hide) hide_q <= wmerged_hide;
      if (rd_load) begin
        data_q <= arr_rdata;
      end else if (wr_fire && wsel_data) begin
        data_q <= wmerged_data[15:0];
      end
    end
  end

  // Saved protection and key survive system resets
  always_ff @(posedge clk or negedge por_nrst) begin
    if (!por_nrst) begin
      saved_q   <= flash_ctrl_pkg::SAVED_RESET;
      key_q     <= flash_ctrl_pkg::KEY_RESET;
      key_set_q <= 1'b0;
    end else if (mass_done) begin
      saved_q   <= flash_ctrl_pkg::SAVED_RESET;
      key_q     <= flash_ctrl_pkg::KEY_RESET;
      key_set_q <= 1'b0;
    end else if (prot_commit) begin
      saved_q   <= prot_q;
      key_q     <= key_in;
      key_set_q <= 1'b1;
    end
  end

  // Saved protection enters force only at the first edge after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= flash_ctrl_pkg::PROT_RESET;
      load_q   <= 1'b1;
    end else if (load_q) begin
      active_q <= saved_q;
      load_q   <= 1'b0;
    end
  end

  // Status flags: a completion in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pass_q    <= 1'b0;
      fail_q    <= 1'b0;
      irqf_q    <= 1'b0;
      flash_irq <= 1'b0;
    end else begin
      pass_q <= (finish && !res_fail_q) || (pass_q && !rd_status);
      fail_q <= (finish && res_fail_q) || (fail_q && !rd_status);
      irqf_q <= (finish && mode_q[flash_ctrl_pkg::MODE_IRQ_EN_BIT]) ||
                (irqf_q && !rd_status);
      flash_irq <= (finish && mode_q[flash_ctrl_pkg::MODE_IRQ_EN_BIT]) ||
                   (irqf_q && !rd_status);
    end
  end

  // Command sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q           <= S_IDLE;
      cmd_q          <= flash_ctrl_pkg::CMD_RESET;
      tmr_q          <= 32'h00000000;
      sidx_q         <= 16'h0000;
      sfold_q        <= 1'b0;
      res_fail_q     <= 1'b0;
      sign_q         <= flash_ctrl_pkg::SIGN_RESET;
      arr_rd         <= 1'b0;
      arr_wr         <= 1'b0;
      arr_erase_page <= 1'b0;
      arr_erase_all  <= 1'b0;
      arr_addr       <= 15'h0000;
      arr_wdata      <= 16'h0000;
    end else begin
      arr_rd         <= 1'b0;
      arr_wr         <= 1'b0;
      arr_erase_page <= 1'b0;
      arr_erase_all  <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            cmd_q <= wdata_q[7:0];
            st_q  <= S_DISPATCH;
          end
        end
        S_DISPATCH: begin
          arr_addr   <= addr_q[15:1];
          arr_wdata  <= data_q;
          res_fail_q <= 1'b0;
          st_q       <= S_FINISH;
          case (cmd_q)
            flash_ctrl_pkg::CMD_READ, flash_ctrl_pkg::CMD_VERIFY: begin
              if (rd_ok && !load_q) begin
                arr_rd <= 1'b1;
                st_q   <= S_RD_WAIT;
              end else begin
                res_fail_q <= 1'b1;
              end
            end
            flash_ctrl_pkg::CMD_WRITE: begin
              if (wr_ok) begin
                arr_wr <= 1'b1;
                tmr_q  <= WRITE_CYC;
                st_q   <= S_WAIT;
              end else begin
                res_fail_q <= 1'b1;
              end
            end
            flash_ctrl_pkg::CMD_ERASEW, flash_ctrl_pkg::CMD_ERASE: begin
              if (wr_ok) begin
                arr_erase_page <= 1'b1;
                tmr_q          <= ERASE_CYC;
                st_q           <= (cmd_q == flash_ctrl_pkg::CMD_ERASEW) ?
                                  S_ERASE_WAIT : S_WAIT;
              end else begin
                res_fail_q <= 1'b1;
              end
            end
            flash_ctrl_pkg::CMD_MASS: begin
              if (mass_ok) begin
                arr_erase_all <= 1'b1;
                arr_addr      <= 15'h7FFF;
                tmr_q         <= MASS_CYC;
                st_q          <= S_WAIT;
              end else begin
                res_fail_q <= 1'b1;
              end
            end
            flash_ctrl_pkg::CMD_SIGN: begin
              sign_q  <= flash_ctrl_pkg::SIGN_RESET;
              sidx_q  <= 16'h0000;
              sfold_q <= 1'b0;
              tmr_q   <= SIGN_CYC;
              st_q    <= S_SIGN;
            end
            flash_ctrl_pkg::CMD_PROTECT: begin
              res_fail_q <= !prot_ok;
            end
            flash_ctrl_pkg::CMD_PING: begin
              res_fail_q <= 1'b0;
            end
            default: begin
              // Null and reserved codes: no operation, no flags
              cmd_q <= code_low ? flash_ctrl_pkg::CMD_IDLE_RB : cmd_q;
              st_q  <= S_IDLE;
            end
          endcase
        end
        S_RD_WAIT: begin
          st_q <= S_RD_TAKE;
        end
        S_RD_TAKE: begin
          if (cmd_q == flash_ctrl_pkg::CMD_VERIFY) begin
            res_fail_q <= arr_rdata != data_q;
          end
          st_q <= S_FINISH;
        end
        S_ERASE_WAIT: begin
          tmr_q <= tmr_q - 32'h00000001;
          if (tmr_q <= 32'h00000001) begin
            arr_wr <= 1'b1;
            tmr_q  <= WRITE_CYC;
            st_q   <= S_WAIT;
          end
        end
        S_WAIT: begin
          tmr_q <= tmr_q - 32'h00000001;
          if (tmr_q <= 32'h00000001) begin
            st_q <= S_FINISH;
          end
        end
        S_SIGN: begin
          tmr_q   <= tmr_q - 32'h00000001;
          // Array data stands the cycle after its strobe: fold then
          sfold_q <= arr_rd;
          if (sidx_q < SIGN_WORDS) begin
            arr_rd   <= 1'b1;
            arr_addr <= sidx_q[14:0];
            sidx_q   <= sidx_q + 16'h0001;
          end
          if (sfold_q) begin
            sign_q <= sig_step(sign_q, arr_rdata);
          end
          if (tmr_q <= 32'h00000001) begin
            st_q <= S_FINISH;
          end
        end
        S_FINISH: begin
          if (code_low) begin
            cmd_q <= flash_ctrl_pkg::CMD_IDLE_RB;
          end
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // flash_command_controller

`default_nettype wire

// ===== hdl/flash_ctrl_pkg.sv
// Constants for the flash command controller: register map, bit fields,
// command codes, reset values and operation times.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package flash_ctrl_pkg;

  // Register byte addresses
  localparam logic [31:0] OFF_STATUS = 32'hFFFFF800;
  localparam logic [31:0] OFF_MODE   = 32'hFFFFF804;
  localparam logic [31:0] OFF_CMD    = 32'hFFFFF808;
  localparam logic [31:0] OFF_DATA   = 32'hFFFFF80C;
  localparam logic [31:0] OFF_ADDR   = 32'hFFFFF810;
  localparam logic [31:0] OFF_SIGN   = 32'hFFFFF818;
  localparam logic [31:0] OFF_PROT   = 32'hFFFFF81C;
  localparam logic [31:0] OFF_HIDE   = 32'hFFFFF820;

  // Mode register fields
  localparam int MODE_KEY_EN_BIT  = 6;
  localparam int MODE_KEY_OFF_BIT = 5;
  localparam int MODE_IRQ_EN_BIT  = 4;
  localparam int MODE_CMD_EN_BIT  = 3;

  // Status register fields
  localparam int ST_PASS_BIT = 0;
  localparam int ST_FAIL_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_IRQ_BIT  = 3;
  localparam int ST_RSV_BIT  = 5;

  // Protection fields
  localparam int PROT_READ_BIT = 31;
  localparam logic [4:0] KERNEL_GROUP = 5'h1F;

  // Reset values
  localparam logic [15:0] MODE_RESET  = 16'h0000;
  localparam logic [7:0]  CMD_RESET   = 8'h07;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [23:0] SIGN_RESET  = 24'hFFFFFF;
  localparam logic [31:0] PROT_RESET  = 32'h00000000;
  localparam logic [31:0] HIDE_RESET  = 32'h0FFFFFFF;
  localparam logic [31:0] SAVED_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] KEY_RESET   = 32'hFFFFFFFF;

  // Command codes
  localparam logic [7:0] CMD_NULL    = 8'h00;
  localparam logic [7:0] CMD_READ    = 8'h01;
  localparam logic [7:0] CMD_WRITE   = 8'h02;
  localparam logic [7:0] CMD_ERASEW  = 8'h03;
  localparam logic [7:0] CMD_VERIFY  = 8'h04;
  localparam logic [7:0] CMD_ERASE   = 8'h05;
  localparam logic [7:0] CMD_MASS    = 8'h06;
  localparam logic [7:0] CMD_IDLE_RB = 8'h07;
  localparam logic [7:0] CMD_SIGN    = 8'h0B;
  localparam logic [7:0] CMD_PROTECT = 8'h0C;
  localparam logic [7:0] CMD_PING    = 8'h0F;

  // Keys
  localparam logic [15:0] MASS_DATA_KEY = 16'h3CFF;
  localparam logic [15:0] MASS_ADDR_KEY = 16'hFFC3;
  localparam logic [31:0] PERM_KEY      = 32'hDEADDEAD;

  // Operation times
  localparam int unsigned CLK_KHZ            = 125000;
  localparam int unsigned WRITE_TIME_US      = 50;
  localparam int unsigned ERASE_WRITE_TIME_MS = 24;
  localparam int unsigned MASS_TIME_MS       = 2480;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_KHZ / 1000;
  localparam int unsigned ERASE_WRITE_CYCLES = ERASE_WRITE_TIME_MS * CLK_KHZ;
  localparam int unsigned PAGE_ERASE_CYCLES =
    ERASE_WRITE_CYCLES - WRITE_CYCLES;
  localparam int unsigned MASS_CYCLES = MASS_TIME_MS * CLK_KHZ;
  localparam int unsigned SIGN_CYCLES = 32778;
  localparam int unsigned SIGN_WORDS  = 32768;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// ===== bench/flash_ctrl_assertions.sv
// Checker for the flash command controller: bus handshakes and strobes.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker (
  // Clock, reset, bus handshakes and interrupt
  input wire logic clk, nrst, s_axi_bvalid, s_axi_bready, s_axi_rvalid,
  input wire logic s_axi_rready, s_axi_arvalid, s_axi_arready, flash_irq,
  // Array strobes
  input wire logic arr_rd, arr_wr, arr_erase_page, arr_erase_all
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read response repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_irq_clear: assert property ($fell(flash_irq) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("irq fell unread");
  a_wr_pulse: assert property (arr_wr |=> !arr_wr)
    else $error("program strobe too long");
  a_page_pulse: assert property (arr_erase_page |=> !arr_erase_page)
    else $error("page erase strobe too long");
  a_mass_pulse: assert property (arr_erase_all |=> !arr_erase_all)
    else $error("mass erase strobe too long");
  a_one_op: assert property ($onehot0({arr_rd, arr_wr,
    arr_erase_page, arr_erase_all})) else $error("strobes overlap");
  c_prog: cover property (arr_wr);
  c_mass: cover property (arr_erase_all);
  c_irq: cover property ($rose(flash_irq));
endmodule // flash_ctrl_checker

bind flash_command_controller flash_ctrl_checker u_chk (.*);
`default_nettype wire

// ===== bench/flash_command_controller_tb.sv
// Testbench for the flash command controller: AXI4-Lite master tasks,
// a flash array model and expected results worked out here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module flash_command_controller_tb;
  localparam logic [31:0] B = 32'hFFFFF800;
  logic        clk = 0, nrst = 0, por_nrst = 0, flash_irq;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic        s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, d;
  logic        irq_s;
  logic [23:0] sig;
  logic        arr_rd, arr_wr, arr_erase_page, arr_erase_all;
  logic [14:0] arr_addr;
  logic [15:0] arr_wdata, arr_rdata = 0, a, v;
  logic [15:0] mem [32768];
  logic [31:0] ro [7] = '{0, 4, 8, 16, 24, 28, 32};
  logic [31:0] rv [7] = '{32'h20, 0, 7, 0, 32'hFFFFFF, 0, 32'h0FFFFFFF};
  logic [7:0]  rc [7] = '{0, 7, 8, 9, 8'hA, 8'hD, 8'hE};
  int          errors = 0, samples_checked = 0;
  flash_command_controller #(.WRITE_CYC(20), .ERASE_CYC(30),
    .MASS_CYC(40), .SIGN_CYC(20), .SIGN_WORDS(16)) dut (.*);
  initial begin
    forever #4 clk = ~clk;
  end
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // Flash array: read data one cycle after the strobe
  always @(posedge clk) begin
    if (arr_rd) arr_rdata <= mem[arr_addr];
    if (arr_wr) mem[arr_addr] <= arr_wdata;
    if (arr_erase_page)
      for (int i = 0; i < 256; i++) mem[{arr_addr[14:8], i[7:0]}] <= '1;
    if (arr_erase_all) for (int i = 0; i < 31744; i++) mem[i] <= '1;
  end
  task automatic wr(input logic [31:0] ad, dt);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [31:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        irq_s = flash_irq;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // Issue a command, poll until idle, compare the final status
  task automatic cmd(input logic [7:0] c, input logic [31:0] e);
    wr(B + 8, {24'h0, c});
    do rd(B); while (d[2] === 1'b1);
    `CHK(d, e)
    `CHK(irq_s, e[3])
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    results();
  end
  initial begin
    void'($urandom(32'hB7AF7B24));
    a = 16'($urandom) & 16'h77FE;
    v = 16'($urandom);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    por_nrst <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (ro[i]) begin
      rd(B + ro[i]);
      `CHK(d, rv[i])
    end
    rd(B + 32'h14);
    `CHK(rsp, 2'b10)
    wr(B + 32'h14, 32'h0);
    `CHK(rsp, 2'b10)
    wr(B + 32'h20, 32'hFFFFFFFF);
    `CHK(rsp, 2'b00)
    wr(B + 12, {16'h0, v});
    wr(B + 16, {16'h0, a});
    cmd(8'h02, 32'h22);
    `CHK(mem[a[15:1]], 16'hFFFF)
    wr(B + 4, 32'h18);
    cmd(8'h02, 32'h29);
    `CHK(mem[a[15:1]], v)
    rd(B + 8);
    `CHK(d, 32'h07)
    wr(B + 12, 32'h0);
    cmd(8'h01, 32'h29);
    rd(B + 12);
    `CHK(d, {16'h0, v})
    cmd(8'h04, 32'h29);
    wr(B + 12, {16'h0, ~v});
    cmd(8'h04, 32'h2A);
    wr(B + 4, 32'h08);
    cmd(8'h03, 32'h21);
    `CHK(mem[a[15:1]], ~v)
    cmd(8'h05, 32'h21);
    `CHK(mem[a[15:1]], 16'hFFFF)
    wr(B + 32'h20, ~(32'h1 << a[15:11]));
    cmd(8'h02, 32'h22);
    wr(B + 32'h20, 32'h7FFFFFFF);
    cmd(8'h01, 32'h22);
    wr(B + 32'h20, 32'hFFFFFFFF);
    cmd(8'h02, 32'h21);
    `CHK(mem[a[15:1]], ~v)
    wr(B + 16, 32'hF800);
    cmd(8'h02, 32'h22);
    cmd(8'h06, 32'h22);
    wr(B + 12, 32'h3CFF);
    wr(B + 16, 32'hFFC3);
    cmd(8'h06, 32'h21);
    `CHK(mem[a[15:1]], 16'hFFFF)
    wr(B + 4, 32'h18);
    cmd(8'h0F, 32'h29);
    foreach (rc[i]) cmd(rc[i], 32'h20);
    // Signature over the first words, one of them random
    wr(B + 12, {16'h0, v});
    wr(B + 16, 32'h2);
    cmd(8'h02, 32'h29);
    sig = 24'hFFFFFF;
    for (int i = 0; i < 16; i++) sig = {sig[22:0], sig[23]} ^ {8'h0, mem[i]};
    cmd(8'h0B, 32'h29);
    rd(B + 24);
    `CHK(d, {8'h0, sig})
    // Saved protection: keyed, in force only after a system reset
    wr(B + 28, ~(32'h1 << a[15:11]));
    wr(B + 4, 32'h48);
    wr(B + 12, 32'h5678);
    wr(B + 16, 32'h1234);
    cmd(8'h0C, 32'h21);
    wr(B + 4, 32'h08);
    wr(B + 12, {16'h0, v});
    wr(B + 16, {16'h0, a});
    cmd(8'h02, 32'h21);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(B + 32);
    `CHK(d, 32'h0FFFFFFF)
    wr(B + 4, 32'h08);
    wr(B + 12, {16'h0, v});
    wr(B + 16, {16'h0, a});
    cmd(8'h02, 32'h22);
    wr(B + 4, 32'h48);
    cmd(8'h0C, 32'h22);
    wr(B + 12, 32'h5678);
    wr(B + 16, 32'h1234);
    cmd(8'h0C, 32'h21);
    results();
  end
endmodule // flash_command_controller_tb
`default_nettype wire
